// >>> hw/flash_guard_pkg.sv
// Constants, register layout and types for the self-programming guard.
// Assumes word-addressed program flash and a single core clock.
package flash_guard_pkg;

  // ============================================================
  // Register port
  localparam int         REG_ADDR_W  = 4;
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_LOCK    = 4'h1;
  localparam logic [3:0] OFS_STATUS  = 4'h2;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // ============================================================
  // Control register fields
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_ERASE_BIT  = 1;
  localparam int CTRL_WRITE_BIT  = 2;
  localparam int CTRL_LOCK_BIT   = 3;
  localparam int CTRL_REEN_BIT   = 4;
  localparam int CTRL_BUSY_BIT   = 6;

  // Command codes in the low five control bits; only the five below other than CMD_NONE are accepted
  localparam logic [4:0] CMD_NONE    = 5'h00;
  localparam logic [4:0] CMD_BUFLOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE   = 5'h03;
  localparam logic [4:0] CMD_WRITE   = 5'h05;
  localparam logic [4:0] CMD_LOCKSET = 5'h09;
  localparam logic [4:0] CMD_REEN    = 5'h11;

  // Store instruction window after arming
  localparam logic [2:0] ARM_CYCLES  = 3'h4;

  // ============================================================
  // Lock fields: bit 1 is the high bit, bit 0 the low bit
  localparam logic [1:0] LOCK_UNPROG  = 2'h3;
  localparam int         LOCK_HI      = 1;
  localparam int         LOCK_LO      = 0;
  localparam int         LOCK_APP_LSB = 2;
  localparam int         LOCK_LDR_LSB = 4;

  // ============================================================
  // Flash geometry defaults, in words
  localparam int FLASH_WORDS_DEF = 16384;
  localparam int HALT_START_DEF  = 14336;
  localparam int LDR_WORDS_0_DEF = 2048;
  localparam int LDR_WORDS_1_DEF = 1024;
  localparam int LDR_WORDS_2_DEF = 512;
  localparam int LDR_WORDS_3_DEF = 256;

  // Flash controller operations
  localparam logic [1:0] FOP_BUFLOAD = 2'h0;
  localparam logic [1:0] FOP_ERASE   = 2'h1;
  localparam logic [1:0] FOP_WRITE   = 2'h2;

  typedef enum {ST_IDLE, ST_ARMED, ST_PROGRAM} op_state_e;

endpackage

// >>> hw/flash_section_self_program_guard.sv
// Access gate for self-programming of on-chip program flash.
// Assumes a core that reports each store/load with its code and target
// addresses, and a flash controller that pulses done after erase or write.
`timescale 1ns/1ps

// Notes on behaviour
// - Stores from application section never program flash
// - Loader-section stores may target any page
// - Loader size fuses set section boundary
// - Fixed boundary splits concurrent and halting regions
// - Stall choice follows target page region
// - Concurrent-region programming does not stall CPU
// - Halting-region programming stalls CPU throughout
// - Loader section always lies in halting region
// - Busy flag reads one while region blocked
// - Two independent two-bit section lock fields
// - Locks program only, cleared by chip erase
// - General lock bits never gate store/load
// - Application level 1 imposes no restriction
// - Application levels 2,3 block application writes
// - Application levels 3,4 block loader-side loads
// - Application levels 3,4 suppress interrupts there
// - Loader level 1 imposes no restriction
// - Loader levels 2,3 block loader writes
// - Loader levels 3,4 block application-side loads
// - Loader levels 3,4 suppress interrupts there
// - Loader-section re-enable store or buffer load clears busy
// - Armed loader-section lock-set store writes lock fields
module flash_section_self_program_guard #(
  parameter int ADDR_W      = 14,
  parameter int FLASH_WORDS = flash_guard_pkg::FLASH_WORDS_DEF,
  parameter int HALT_START  = flash_guard_pkg::HALT_START_DEF,
  parameter int LDR_WORDS_0 = flash_guard_pkg::LDR_WORDS_0_DEF,
  parameter int LDR_WORDS_1 = flash_guard_pkg::LDR_WORDS_1_DEF,
  parameter int LDR_WORDS_2 = flash_guard_pkg::LDR_WORDS_2_DEF,
  parameter int LDR_WORDS_3 = flash_guard_pkg::LDR_WORDS_3_DEF
) (
  input  wire logic                                  SYS_CLK,
  input  wire logic                                  SRST,
  input  wire logic                                  CLK_EN,
  input  wire logic [flash_guard_pkg::REG_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]                            WDATA,
  input  wire logic                                  WR_STB,
  input  wire logic                                  RD_STB,
  output logic      [7:0]                            RDATA,
  input  wire logic [1:0]                            LOADER_SIZE_FUSES,
  input  wire logic [1:0]                            LOCK_NV_APP,
  input  wire logic [1:0]                            LOCK_NV_LDR,
  input  wire logic                                  CHIP_ERASE,
  input  wire logic                                  EXT_LOCK_WR,
  input  wire logic [3:0]                            EXT_LOCK_DATA,
  input  wire logic                                  STORE_REQ,
  input  wire logic [ADDR_W-1:0]                     STORE_PC,
  input  wire logic [ADDR_W-1:0]                     STORE_TGT,
  input  wire logic [15:0]                           STORE_DATA,
  input  wire logic                                  LOAD_REQ,
  input  wire logic [ADDR_W-1:0]                     LOAD_PC,
  input  wire logic [ADDR_W-1:0]                     LOAD_TGT,
  output logic                                       LOAD_ALLOW,
  input  wire logic [ADDR_W-1:0]                     FETCH_PC,
  input  wire logic                                  IVEC_IN_LOADER,
  output logic                                       IRQ_ALLOW,
  output logic                                       FLASH_START,
  output logic      [1:0]                            FLASH_OP,
  output logic      [ADDR_W-1:0]                     FLASH_PAGE,
  output logic      [15:0]                           FLASH_DATA,
  input  wire logic                                  FLASH_DONE,
  output logic                                       CPU_STALL,
  output logic                                       REGION_BUSY,
  output logic      [1:0]                            APP_LOCK,
  output logic      [1:0]                            LDR_LOCK
);
  import flash_guard_pkg::*;

  // ============================================================
  // Section decode
  function automatic int loader_start(input logic [1:0] fz);
    int words;
    int start;
    case (fz)
      2'h0:    words = LDR_WORDS_0;
      2'h1:    words = LDR_WORDS_1;
      2'h2:    words = LDR_WORDS_2;
      default: words = LDR_WORDS_3;
    endcase
    start = FLASH_WORDS - words;
    if (start < HALT_START) begin
      start = HALT_START;
    end
    return start;
  endfunction

  function automatic logic in_loader(input logic [ADDR_W-1:0] a, input logic [1:0] fz);
    return int'(a) >= loader_start(fz);
  endfunction

  function automatic logic in_concurrent(input logic [ADDR_W-1:0] a);
    return int'(a) < HALT_START;
  endfunction

  // ============================================================
  // State
  op_state_e   state_ff;
  logic [4:0]  cmd_ff;
  logic [2:0]  arm_cnt_ff;
  logic        tgt_crr_ff;
  logic        region_busy_ff;
  logic [1:0]  app_lock_ff;
  logic [1:0]  ldr_lock_ff;
  logic        start_ff;
  logic [1:0]  fop_ff;
  logic [ADDR_W-1:0] fpage_ff;
  logic [15:0] fdata_ff;
  logic [7:0]  rdata_ff;

  // ============================================================
  // Request decode
  logic       wr_ctrl;
  logic       wcmd_ok;
  logic       store_go;
  logic       from_app;
  logic       tgt_ldr;
  logic       tgt_crr;
  logic       wr_blocked;
  logic       act_bufload;
  logic       act_prog;
  logic       act_lockset;
  logic       act_reen;

  assign wr_ctrl  = WR_STB && (ADDR == OFS_CTRL);
  assign wcmd_ok  = (WDATA[4:0] == CMD_BUFLOAD) || (WDATA[4:0] == CMD_ERASE) ||
                    (WDATA[4:0] == CMD_WRITE) || (WDATA[4:0] == CMD_LOCKSET) ||
                    (WDATA[4:0] == CMD_REEN);
  assign store_go = STORE_REQ && (state_ff == ST_ARMED);
  assign from_app = !in_loader(STORE_PC, LOADER_SIZE_FUSES);
  assign tgt_ldr  = in_loader(STORE_TGT, LOADER_SIZE_FUSES);
  assign tgt_crr  = in_concurrent(STORE_TGT);

  // Writes gated by the low bit of the target section's field only
  assign wr_blocked = tgt_ldr ? !ldr_lock_ff[LOCK_LO] : !app_lock_ff[LOCK_LO];

  assign act_bufload = store_go && !from_app && (cmd_ff == CMD_BUFLOAD);
  assign act_prog    = store_go && !from_app && !wr_blocked &&
                       ((cmd_ff == CMD_ERASE) || (cmd_ff == CMD_WRITE));
  assign act_lockset = store_go && !from_app && (cmd_ff == CMD_LOCKSET);
  assign act_reen    = store_go && !from_app && (cmd_ff == CMD_REEN);

  // ============================================================
  // Command sequencer
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_ff   <= ST_IDLE;
      cmd_ff     <= CMD_NONE;
      arm_cnt_ff <= 3'h0;
    end else if (CLK_EN) begin
      case (state_ff)
        ST_IDLE: begin
          if (wr_ctrl && wcmd_ok) begin
            state_ff   <= ST_ARMED;
            cmd_ff     <= WDATA[4:0];
            arm_cnt_ff <= ARM_CYCLES;
          end
        end
        ST_ARMED: begin
          if (act_prog) begin
            state_ff <= ST_PROGRAM;
          end else if (store_go) begin
            state_ff <= ST_IDLE;
            cmd_ff   <= CMD_NONE;
          end else if (wr_ctrl && wcmd_ok) begin
            cmd_ff     <= WDATA[4:0];
            arm_cnt_ff <= ARM_CYCLES;
          end else if (arm_cnt_ff == 3'h1) begin
            state_ff <= ST_IDLE;
            cmd_ff   <= CMD_NONE;
          end else begin
            arm_cnt_ff <= arm_cnt_ff - 3'h1;
          end
        end
        ST_PROGRAM: begin
          if (FLASH_DONE) begin
            state_ff <= ST_IDLE;
            cmd_ff   <= CMD_NONE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          cmd_ff   <= CMD_NONE;
        end
      endcase
    end
  end

  // ============================================================
  // Target region of the running operation
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      tgt_crr_ff <= 1'b0;
    end else if (CLK_EN && act_prog) begin
      tgt_crr_ff <= tgt_crr;
    end
  end

  // ============================================================
  // Region busy flag
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      region_busy_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (act_prog && tgt_crr) begin
        region_busy_ff <= 1'b1;
      end else if (act_reen || act_bufload) begin
        region_busy_ff <= 1'b0;
      end
    end
  end

  // ============================================================
  // Section lock fields
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      app_lock_ff <= LOCK_NV_APP;
      ldr_lock_ff <= LOCK_NV_LDR;
    end else if (CLK_EN) begin
      if (CHIP_ERASE) begin
        app_lock_ff <= LOCK_UNPROG;
        ldr_lock_ff <= LOCK_UNPROG;
      end else if (EXT_LOCK_WR) begin
        app_lock_ff <= app_lock_ff & EXT_LOCK_DATA[1:0];
        ldr_lock_ff <= ldr_lock_ff & EXT_LOCK_DATA[3:2];
      end else if (act_lockset) begin
        app_lock_ff <= app_lock_ff & STORE_DATA[LOCK_APP_LSB +: 2];
        ldr_lock_ff <= ldr_lock_ff & STORE_DATA[LOCK_LDR_LSB +: 2];
      end
    end
  end

  // ============================================================
  // Flash controller request
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      start_ff <= 1'b0;
      fop_ff   <= FOP_BUFLOAD;
      fpage_ff <= '0;
      fdata_ff <= 16'h0000;
    end else if (CLK_EN) begin
      start_ff <= act_prog || act_bufload;
      if (act_prog || act_bufload) begin
        fop_ff   <= act_bufload ? FOP_BUFLOAD : ((cmd_ff == CMD_ERASE) ? FOP_ERASE : FOP_WRITE);
        fpage_ff <= STORE_TGT;
        fdata_ff <= STORE_DATA;
      end
    end
  end

  // ============================================================
  // Register read port
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_ff <= CTRL_RESET;
    end else if (CLK_EN) begin
      rdata_ff <= 8'h00;
      if (RD_STB) begin
        case (ADDR)
          OFS_CTRL:   rdata_ff <= {1'b0, region_busy_ff, 1'b0, cmd_ff};
          OFS_LOCK:   rdata_ff <= {4'h0, ldr_lock_ff, app_lock_ff};
          OFS_STATUS: rdata_ff <= {5'h00, region_busy_ff, CPU_STALL, state_ff == ST_PROGRAM};
          default:    rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  // ============================================================
  // Load and interrupt gating
  logic load_pc_ldr;
  logic load_tgt_ldr;
  logic fetch_ldr;

  assign load_pc_ldr  = in_loader(LOAD_PC, LOADER_SIZE_FUSES);
  assign load_tgt_ldr = in_loader(LOAD_TGT, LOADER_SIZE_FUSES);
  assign fetch_ldr    = in_loader(FETCH_PC, LOADER_SIZE_FUSES);

  // Reads gated by the high bit only; levels 1 and 2 pass
  always_comb begin
    LOAD_ALLOW = 1'b1;
    if (load_pc_ldr && !load_tgt_ldr && !app_lock_ff[LOCK_HI]) begin
      LOAD_ALLOW = 1'b0;
    end
    if (!load_pc_ldr && load_tgt_ldr && !ldr_lock_ff[LOCK_HI]) begin
      LOAD_ALLOW = 1'b0;
    end
  end

  always_comb begin
    IRQ_ALLOW = 1'b1;
    if (IVEC_IN_LOADER && !fetch_ldr && !app_lock_ff[LOCK_HI]) begin
      IRQ_ALLOW = 1'b0;
    end
    if (!IVEC_IN_LOADER && fetch_ldr && !ldr_lock_ff[LOCK_HI]) begin
      IRQ_ALLOW = 1'b0;
    end
  end

  // ============================================================
  // Outputs
  assign CPU_STALL   = (state_ff == ST_PROGRAM) && !tgt_crr_ff;
  assign REGION_BUSY = region_busy_ff;
  assign FLASH_START = start_ff;
  assign FLASH_OP    = fop_ff;
  assign FLASH_PAGE  = fpage_ff;
  assign FLASH_DATA  = fdata_ff;
  assign RDATA       = rdata_ff;
  assign APP_LOCK    = app_lock_ff;
  assign LDR_LOCK    = ldr_lock_ff;

  // ============================================================
  // Checks
  property p_app_store_refused;
    @(posedge SYS_CLK) disable iff (SRST)
    (CLK_EN && STORE_REQ && !in_loader(STORE_PC, LOADER_SIZE_FUSES)) |=> !FLASH_START;
  endproperty
  a_app_store_refused: assert property (p_app_store_refused) else $error("store from application started flash");

  property p_halt_stall;
    @(posedge SYS_CLK) disable iff (SRST)
    (CLK_EN && act_prog && !tgt_crr) |=> CPU_STALL && (FLASH_OP != FOP_BUFLOAD);
  endproperty
  a_halt_stall: assert property (p_halt_stall) else $error("halting region program did not stall");

  property p_halt_stall_hold;
    @(posedge SYS_CLK) disable iff (SRST)
    (CPU_STALL && !FLASH_DONE) |=> CPU_STALL;
  endproperty
  a_halt_stall_hold: assert property (p_halt_stall_hold) else $error("stall dropped before done");

  property p_crr_no_stall;
    @(posedge SYS_CLK) disable iff (SRST)
    (CLK_EN && act_prog && tgt_crr) |=> !CPU_STALL && REGION_BUSY;
  endproperty
  a_crr_no_stall: assert property (p_crr_no_stall) else $error("concurrent region program stalled");

  property p_busy_read;
    @(posedge SYS_CLK) disable iff (SRST)
    (CLK_EN && RD_STB && (ADDR == OFS_CTRL) && REGION_BUSY) |=> RDATA[CTRL_BUSY_BIT];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy flag read as zero");

  property p_app_load_block;
    @(posedge SYS_CLK) disable iff (SRST)
    (LOAD_REQ && load_pc_ldr && !load_tgt_ldr && !APP_LOCK[LOCK_HI]) |-> !LOAD_ALLOW;
  endproperty
  a_app_load_block: assert property (p_app_load_block) else $error("loader read of application allowed");

  property p_ldr_load_block;
    @(posedge SYS_CLK) disable iff (SRST)
    (LOAD_REQ && !load_pc_ldr && load_tgt_ldr && !LDR_LOCK[LOCK_HI]) |-> !LOAD_ALLOW;
  endproperty
  a_ldr_load_block: assert property (p_ldr_load_block) else $error("application read of loader allowed");

  property p_lock_one_way;
    @(posedge SYS_CLK) disable iff (SRST)
    (CLK_EN && !CHIP_ERASE) |=> ((APP_LOCK & ~$past(APP_LOCK)) == 2'h0) && ((LDR_LOCK & ~$past(LDR_LOCK)) == 2'h0);
  endproperty
  a_lock_one_way: assert property (p_lock_one_way) else $error("lock bit cleared without chip erase");

  property p_blocked_write;
    @(posedge SYS_CLK) disable iff (SRST)
    (CLK_EN && store_go && wr_blocked && ((cmd_ff == CMD_ERASE) || (cmd_ff == CMD_WRITE))) |=>
      !FLASH_START ##1 !CPU_STALL;
  endproperty
  a_blocked_write: assert property (p_blocked_write) else $error("locked write started flash");

  property p_reen_clears;
    @(posedge SYS_CLK) disable iff (SRST)
    (CLK_EN && (act_reen || act_bufload)) |=> !REGION_BUSY;
  endproperty
  a_reen_clears: assert property (p_reen_clears) else $error("busy flag not cleared");

endmodule

// >>> sim/core_model.sv
// Core and flash controller model facing the guard.
// Assumes the bench calls store at a rising edge of clk.
`timescale 1ns/1ps
module core_model
  import flash_guard_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [7:0]  dly,
  input  wire logic        flash_start,
  input  wire logic [1:0]  flash_op,
  output logic             store_req,
  output logic [13:0]      store_pc,
  output logic [13:0]      store_tgt,
  output logic [15:0]      store_data,
  output logic             flash_done
);
  logic [7:0] cnt;

  initial begin
    store_req  = 1'b0;
    store_pc   = 14'h0000;
    store_tgt  = 14'h0000;
    store_data = 16'h0000;
    flash_done = 1'b0;
    cnt        = 8'h00;
  end

  // ============================================================
  // Store issue, fields inverted once released
  task automatic store(input logic [13:0] pc, input logic [13:0] tgt, input logic [15:0] d, input int gap);
    repeat (gap) @(posedge clk);
    store_pc   <= pc;
    store_tgt  <= tgt;
    store_data <= d;
    store_req  <= 1'b1;
    @(posedge clk);
    store_req  <= 1'b0;
    store_pc   <= ~pc;
    store_tgt  <= ~tgt;
    store_data <= ~d;
  endtask

  // ============================================================
  // Erase or write ends after dly cycles
  always @(posedge clk) begin
    flash_done <= 1'b0;
    if (flash_start && flash_op != FOP_BUFLOAD) begin
      cnt <= dly;
    end else if (cnt == 8'h01) begin
      cnt        <= 8'h00;
      flash_done <= 1'b1;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the self-programming guard.
// Assumes default flash geometry: halting and loader start at 14'h3800.
`timescale 1ns/1ps
module testbench;
  import flash_guard_pkg::*;

  localparam logic [13:0] PC_APP = 14'h0100;
  localparam logic [13:0] PC_MID = 14'h3900;
  localparam logic [13:0] PC_LDR = 14'h3f80;
  localparam logic [13:0] T_APP  = 14'h0200;
  localparam logic [13:0] T_HALT = 14'h3a00;
  localparam logic [13:0] T_LDR  = 14'h3c00;

  logic        clk, srst, clk_en, wr_stb, rd_stb, chip_erase, ext_lock_wr, load_req, ivec;
  logic [3:0]  addr, ext_lock_data;
  logic [7:0]  wdata, rdata, dly;
  logic [1:0]  fuses, flash_op, app_lock, ldr_lock;
  logic [13:0] load_pc, load_tgt, fetch_pc, store_pc, store_tgt, flash_page;
  logic [15:0] store_data, flash_data;
  logic        store_req, load_allow, irq_allow, flash_start, flash_done, cpu_stall, region_busy;
  logic [1:0]  lv [4];
  int          error_cnt, checks_done;

  flash_section_self_program_guard flash_section_self_program_guard_inst (
    .SYS_CLK(clk), .SRST(srst), .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .LOADER_SIZE_FUSES(fuses), .LOCK_NV_APP(2'h3), .LOCK_NV_LDR(2'h3),
    .CHIP_ERASE(chip_erase), .EXT_LOCK_WR(ext_lock_wr), .EXT_LOCK_DATA(ext_lock_data),
    .STORE_REQ(store_req), .STORE_PC(store_pc), .STORE_TGT(store_tgt), .STORE_DATA(store_data),
    .LOAD_REQ(load_req), .LOAD_PC(load_pc), .LOAD_TGT(load_tgt), .LOAD_ALLOW(load_allow),
    .FETCH_PC(fetch_pc), .IVEC_IN_LOADER(ivec), .IRQ_ALLOW(irq_allow), .FLASH_START(flash_start),
    .FLASH_OP(flash_op), .FLASH_PAGE(flash_page), .FLASH_DATA(flash_data), .FLASH_DONE(flash_done),
    .CPU_STALL(cpu_stall), .REGION_BUSY(region_busy), .APP_LOCK(app_lock), .LDR_LOCK(ldr_lock));

  core_model core_model_inst (
    .clk(clk), .dly(dly), .flash_start(flash_start), .flash_op(flash_op), .store_req(store_req),
    .store_pc(store_pc), .store_tgt(store_tgt), .store_data(store_data), .flash_done(flash_done));

  // ============================================================
  // Compare, bus and sequence tasks
  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk_reg(rdata, exp);
  endtask

  task automatic prog(input logic [4:0] cmd, input logic [13:0] pc, input logic [13:0] tgt,
                      input logic [15:0] d, input int gap);
    wr(OFS_CTRL, {3'h0, cmd});
    core_model_inst.store(pc, tgt, d, gap);
    #1;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (flash_done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk_sig({15'h0, n >= 300}, 16'h0000);
    chk_sig({15'h0, cpu_stall}, 16'h0000);
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic set_locks(input logic [3:0] d);
    @(posedge clk);
    chip_erase <= 1'b1;
    @(posedge clk);
    chip_erase    <= 1'b0;
    ext_lock_data <= d;
    ext_lock_wr   <= 1'b1;
    @(posedge clk);
    ext_lock_wr <= 1'b0;
    #1;
  endtask

  task automatic probe(input logic [13:0] lp, input logic [13:0] lt, input logic [13:0] fp, input logic iv);
    @(posedge clk);
    load_pc  <= lp;
    load_tgt <= lt;
    fetch_pc <= fp;
    ivec     <= iv;
    load_req <= 1'b1;
    #1;
  endtask

  task automatic conclude();
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ============================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  // ============================================================
  // Tests
  initial begin
    {srst, wr_stb, rd_stb, chip_erase, ext_lock_wr, load_req, ivec} = 7'b1000000;
    clk_en = 1'b1;
    {addr, ext_lock_data, wdata, fuses, dly} = '0;
    {load_pc, load_tgt, fetch_pc} = {PC_LDR, PC_LDR, PC_LDR};
    lv = '{2'b11, 2'b10, 2'b00, 2'b01};
    error_cnt = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_LOCK, 8'h0f);
    rd(4'hf, 8'h00);
    prog(CMD_ERASE, PC_APP, T_HALT, 16'h0, 0);
    chk_sig({15'h0, flash_start}, 16'h0000);
    rd(OFS_CTRL, 8'h00);
    dly <= 8'd10;
    prog(CMD_ERASE, PC_MID, T_LDR, 16'h0, 0);
    chk_sig({12'h0, flash_start, cpu_stall, region_busy, 1'b0}, 16'h000c);
    chk_sig({flash_op, flash_page}, {FOP_ERASE, T_LDR});
    rd(OFS_STATUS, 8'h03);
    wait_done();
    dly <= 8'd6;
    prog(CMD_WRITE, PC_LDR, T_APP, 16'h0, 0);
    chk_sig({12'h0, flash_start, cpu_stall, region_busy, 1'b0}, 16'h000a);
    chk_sig({14'h0, flash_op}, {14'h0, FOP_WRITE});
    rd(OFS_CTRL, 8'h45);
    wait_done();
    rd(OFS_STATUS, 8'h04);
    prog(CMD_REEN, PC_LDR, T_APP, 16'h0, 0);
    settle();
    chk_sig({15'h0, region_busy}, 16'h0000);
    prog(CMD_WRITE, PC_LDR, T_APP, 16'h0, 0);
    wait_done();
    prog(CMD_BUFLOAD, PC_LDR, T_APP, 16'h5aa5, 0);
    chk_sig(flash_data, 16'h5aa5);
    settle();
    chk_sig({15'h0, region_busy}, 16'h0000);
    @(posedge clk);
    fuses <= 2'b11;
    prog(CMD_ERASE, PC_MID, T_HALT, 16'h0, 0);
    chk_sig({15'h0, flash_start}, 16'h0000);
    prog(CMD_ERASE, PC_LDR, T_HALT, 16'h0, 0);
    chk_sig({14'h0, flash_start, cpu_stall}, 16'h0003);
    wait_done();
    @(posedge clk);
    fuses <= 2'b00;
    wr(OFS_CTRL, 8'h07);
    rd(OFS_CTRL, 8'h00);
    prog(CMD_LOCKSET, PC_LDR, 14'h0, 16'h0038, 3);
    settle();
    chk_sig({12'h0, ldr_lock, app_lock}, 16'h000e);
    prog(CMD_LOCKSET, PC_LDR, 14'h0, 16'h0000, 4);
    settle();
    chk_sig({12'h0, ldr_lock, app_lock}, 16'h000e);
    rd(OFS_LOCK, 8'h0e);
    wr(OFS_LOCK, 8'h00);
    rd(OFS_LOCK, 8'h0e);
    @(posedge clk);
    clk_en <= 1'b0;
    set_locks(4'h0);
    chk_sig({12'h0, ldr_lock, app_lock}, 16'h000e);
    @(posedge clk);
    clk_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      set_locks({lv[3-i], lv[i]});
      chk_sig({12'h0, ldr_lock, app_lock}, {12'h0, lv[3-i], lv[i]});
      probe(PC_LDR, T_APP, PC_APP, 1'b1);
      chk_sig({14'h0, load_allow, irq_allow}, {14'h0, lv[i][1], lv[i][1]});
      probe(PC_APP, T_LDR, PC_LDR, 1'b0);
      chk_sig({14'h0, load_allow, irq_allow}, {14'h0, lv[3-i][1], lv[3-i][1]});
      probe(PC_APP, T_LDR, PC_LDR, 1'b1);
      chk_sig({15'h0, irq_allow}, 16'h0001);
      prog(CMD_ERASE, PC_LDR, T_APP, 16'h0, 0);
      chk_sig({15'h0, flash_start}, {15'h0, lv[i][0]});
      if (lv[i][0]) wait_done();
      prog(CMD_ERASE, PC_LDR, T_LDR, 16'h0, 0);
      chk_sig({15'h0, flash_start}, {15'h0, lv[3-i][0]});
      if (lv[3-i][0]) wait_done();
    end
    set_locks(4'hf);
    chk_sig({12'h0, ldr_lock, app_lock}, 16'h000f);
    conclude();
  end
endmodule
